// File: hdl/irc_consts.svh
// Constants for input routing and edge capture
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH
`define IRC_NUM_BITS 36
`define IRC_ADDR_W 8
// Register index map (word addresses on the plain port)
`define IRC_A_ROUTE_CNT 8'h00
`define IRC_A_ROUTE_BASE 8'h01
`define IRC_A_ROUTE_LAST 8'h24
`define IRC_A_CAP_CNT 8'h40
`define IRC_A_CAP_CTRL 8'h41
`define IRC_A_CAP_COUNT 8'h42
`define IRC_A_CAP_POS 8'h43
`define IRC_A_CAP_RAW 8'h44
`define IRC_A_IN_WORD_LO 8'h50
`define IRC_A_IN_WORD_HI 8'h51
`define IRC_A_IRQ_STAT 8'h60
`define IRC_A_IRQ_MASK 8'h61
// Reset values
`define IRC_ROUTE_CNT_VAL 8'h24
`define IRC_CAP_CNT_VAL 8'h04
`define IRC_SRC_RST 8'h00
// Source codes
`define IRC_SRC_ZERO 8'h00
`define IRC_SRC_PIN_LO 8'h01
`define IRC_SRC_PIN_HI 8'h10
`define IRC_SRC_ENC_A 8'h44
`define IRC_SRC_ENC_B 8'h45
`define IRC_SRC_ENC_I 8'h46
`define IRC_SRC_USB 8'h47
`define IRC_SRC_DIP_LO 8'h49
`define IRC_SRC_DIP_HI 8'h50
`define IRC_SRC_ONE 8'h80
`define IRC_SRC_INV_BIT 7
// Interrupt status bits
`define IRC_IRQ_CAPTURE 0
`define IRC_IRQ_W 1
`endif

// File: hdl/irc_pkg.sv
// Types for input routing and edge capture
package irc_pkg;
  typedef enum logic [1:0] {
    IRC_EDGE_OFF,
    IRC_EDGE_RISE,
    IRC_EDGE_FALL,
    IRC_EDGE_BOTH
  } irc_edge_t;
  typedef logic [7:0] irc_code_t;
endpackage : irc_pkg

// File: hdl/irc_route_bit.sv
// One routed bit: decodes a source code into a level
`timescale 1ns/1ps
`default_nettype none
`include "irc_consts.svh"
module irc_route_bit (
  irc_src_if.dst src,
  input wire irc_pkg::irc_code_t code_i,
  output logic bit_o
);
  import irc_pkg::*;
  logic [6:0] base;
  logic raw;
  logic valid;
  logic inv;
  always_comb begin
    base = code_i[6:0];
    inv = code_i[`IRC_SRC_INV_BIT];
    raw = 1'b0;
    valid = 1'b0;
    if (base == 7'h00) begin
      valid = 1'b1;
    end else if (base <= 7'h10) begin
      raw = src.pins[4'(base - 7'h01)];
      valid = 1'b1;
    end else if (base >= 7'h44 && base <= 7'h47) begin
      valid = 1'b1;
      case (base[1:0])
        2'h0: raw = src.enc_a;
        2'h1: raw = src.enc_b;
        2'h2: raw = src.enc_i;
        default: raw = src.usb;
      endcase
    end else if (!inv && base >= 7'h49 && base <= 7'h50) begin
      raw = src.dip[3'(base - 7'h49)];
      valid = 1'b1;
    end
    // Inverted codes 80h..90h, C4h..C7h; DIP has no inverse
    if (!valid) begin
      bit_o = 1'b0;
    end else begin
      bit_o = raw ^ inv;
    end
  end
endmodule : irc_route_bit
`default_nettype wire

// File: hdl/irc_src_if.sv
// Routing sources shared between top and source decoder
`timescale 1ns/1ps
`default_nettype none
interface irc_src_if;
  logic [15:0] pins;
  logic enc_a;
  logic enc_b;
  logic enc_i;
  logic usb;
  logic [7:0] dip;
  modport src (output pins, enc_a, enc_b, enc_i, usb, dip);
  modport dst (input pins, enc_a, enc_b, enc_i, usb, dip);
endinterface : irc_src_if
`default_nettype wire

// File: hdl/irc_top.sv
// Input routing with home-switch edge capture
//
// Function
// - 36 writable 8-bit source codes at entries 01h..24h, reset 00h.
// - Entry n drives bit n-1 of the digital input word.
// - Code 00h gives constant 0, code 80h gives constant 1.
// - Codes 01h..10h route physical inputs 1..16 unchanged.
// - Codes 44h..47h encoder A, B, index, USB; 49h..50h DIP 1..8.
// - Codes 81h..90h route inverted physical inputs 1..16.
// - Codes C4h..C7h route inverted encoder A, B, index, USB.
// - Qualifying home-switch edge latches position while capture enabled.
// - Control 0 off, 1 rising, 2 falling, 3 both edges.
// - 32-bit capture count, cleared when control written 1, 2 or 3.
// - Each capture stores actual position in user units.
// - Each capture also stores the raw sensor position.
`timescale 1ns/1ps
`default_nettype none
`include "irc_consts.svh"
module irc_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [`IRC_ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic [15:0] PIN_I,
  input wire logic ENC_A_I,
  input wire logic ENC_B_I,
  input wire logic ENC_IDX_I,
  input wire logic USB_PWR_I,
  input wire logic [7:0] DIP_I,
  input wire logic HOME_I,
  input wire logic [31:0] ACT_POS_I,
  input wire logic [31:0] RAW_POS_I,
  output logic [35:0] IN_WORD_O,
  output logic IRQ_O
);
  import irc_pkg::*;

  // ****************************************
  // Source selection
  // ****************************************
  irc_code_t src_sel_ff [`IRC_NUM_BITS];
  logic [35:0] nxt_in_word;
  irc_src_if srcs ();
  assign srcs.pins = PIN_I;
  assign srcs.enc_a = ENC_A_I;
  assign srcs.enc_b = ENC_B_I;
  assign srcs.enc_i = ENC_IDX_I;
  assign srcs.usb = USB_PWR_I;
  assign srcs.dip = DIP_I;

  logic wr_route;
  logic [5:0] route_idx;
  assign wr_route = WR_I && ADDR_I >= `IRC_A_ROUTE_BASE &&
                    ADDR_I <= `IRC_A_ROUTE_LAST;
  assign route_idx = 6'(ADDR_I - `IRC_A_ROUTE_BASE);

  genvar gi;
  generate
    for (gi = 0; gi < `IRC_NUM_BITS; gi++) begin : g_bit
      always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          src_sel_ff[gi] <= `IRC_SRC_RST;
        end else if (CE_I && wr_route && route_idx == 6'(gi)) begin
          src_sel_ff[gi] <= WDATA_I[7:0];
        end
      end
      irc_route_bit u_bit (
        .src(srcs),
        .code_i(src_sel_ff[gi]),
        .bit_o(nxt_in_word[gi])
      );
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IN_WORD_O <= 36'h0;
    end else if (CE_I) begin
      IN_WORD_O <= nxt_in_word;
    end
  end

  // ****************************************
  // Home-switch edge capture
  // ****************************************
  // Two stages before the edge detector; the third stage is the history
  logic home_s1_ff;
  logic home_s2_ff;
  logic home_s3_ff;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      home_s1_ff <= 1'b0;
      home_s2_ff <= 1'b0;
      home_s3_ff <= 1'b0;
    end else if (CE_I) begin
      home_s1_ff <= HOME_I;
      home_s2_ff <= home_s1_ff;
      home_s3_ff <= home_s2_ff;
    end
  end

  irc_edge_t cap_mode_ff;
  logic [31:0] cap_ctrl_ff;
  logic [31:0] cap_count_ff;
  logic [31:0] cap_pos_ff;
  logic [31:0] cap_raw_ff;
  logic rise;
  logic fall;
  logic hit;
  logic wr_ctrl;
  assign rise = home_s2_ff && !home_s3_ff;
  assign fall = !home_s2_ff && home_s3_ff;
  assign wr_ctrl = WR_I && ADDR_I == `IRC_A_CAP_CTRL;

  always_comb begin
    case (cap_mode_ff)
      IRC_EDGE_RISE: hit = rise;
      IRC_EDGE_FALL: hit = fall;
      IRC_EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
  end

  // Full word kept for readback; only values 1..3 arm the edge logic
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cap_ctrl_ff <= 32'h0;
      cap_mode_ff <= IRC_EDGE_OFF;
    end else if (CE_I && wr_ctrl) begin
      cap_ctrl_ff <= WDATA_I;
      if (WDATA_I <= 32'h3) begin
        cap_mode_ff <= irc_edge_t'(WDATA_I[1:0]);
      end else begin
        cap_mode_ff <= IRC_EDGE_OFF;
      end
    end
  end

  // Control write restarting capture wins over an edge in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cap_count_ff <= 32'h0;
    end else if (CE_I) begin
      if (wr_ctrl && WDATA_I >= 32'h1 && WDATA_I <= 32'h3) begin
        cap_count_ff <= 32'h0;
      end else if (hit) begin
        cap_count_ff <= cap_count_ff + 32'h1;
      end else if (WR_I && ADDR_I == `IRC_A_CAP_COUNT) begin
        cap_count_ff <= WDATA_I;
      end
    end
  end

  // Edge beats a software write to the value entries
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cap_pos_ff <= 32'h0;
      cap_raw_ff <= 32'h0;
    end else if (CE_I) begin
      if (hit) begin
        cap_pos_ff <= ACT_POS_I;
        cap_raw_ff <= RAW_POS_I;
      end else begin
        if (WR_I && ADDR_I == `IRC_A_CAP_POS) begin
          cap_pos_ff <= WDATA_I;
        end
        if (WR_I && ADDR_I == `IRC_A_CAP_RAW) begin
          cap_raw_ff <= WDATA_I;
        end
      end
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [`IRC_IRQ_W-1:0] irq_stat_ff;
  logic [`IRC_IRQ_W-1:0] irq_mask_ff;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat_ff <= '0;
    end else if (CE_I) begin
      // Set wins over write-one-to-clear
      irq_stat_ff[`IRC_IRQ_CAPTURE] <= hit ||
        (irq_stat_ff[`IRC_IRQ_CAPTURE] &&
         !(WR_I && ADDR_I == `IRC_A_IRQ_STAT &&
           WDATA_I[`IRC_IRQ_CAPTURE]));
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_mask_ff <= '0;
    end else if (CE_I && WR_I && ADDR_I == `IRC_A_IRQ_MASK) begin
      irq_mask_ff <= WDATA_I[`IRC_IRQ_W-1:0];
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ****************************************
  // Register readback
  // ****************************************
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0;
    if (ADDR_I >= `IRC_A_ROUTE_BASE && ADDR_I <= `IRC_A_ROUTE_LAST) begin
      nxt_rdata = {24'h0, src_sel_ff[route_idx]};
    end else begin
      case (ADDR_I)
        `IRC_A_ROUTE_CNT: nxt_rdata = {24'h0, `IRC_ROUTE_CNT_VAL};
        `IRC_A_CAP_CNT: nxt_rdata = {24'h0, `IRC_CAP_CNT_VAL};
        `IRC_A_CAP_CTRL: nxt_rdata = cap_ctrl_ff;
        `IRC_A_CAP_COUNT: nxt_rdata = cap_count_ff;
        `IRC_A_CAP_POS: nxt_rdata = cap_pos_ff;
        `IRC_A_CAP_RAW: nxt_rdata = cap_raw_ff;
        `IRC_A_IN_WORD_LO: nxt_rdata = IN_WORD_O[31:0];
        `IRC_A_IN_WORD_HI: nxt_rdata = {28'h0, IN_WORD_O[35:32]};
        `IRC_A_IRQ_STAT: nxt_rdata = {31'h0, irq_stat_ff};
        `IRC_A_IRQ_MASK: nxt_rdata = {31'h0, irq_mask_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0;
    end else if (CE_I) begin
      RDATA_O <= RD_I ? nxt_rdata : 32'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_src_reset;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> src_sel_ff[0] == 8'h00;
  endproperty
  a_src_reset: assert property (p_src_reset)
    else $error("bad reset code");
  // Entries picked where the bench's code sweep parks each code, except src_sel_ff[7], checked at reset code 00h
  property p_const_one;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[20] == 8'h80 |=> IN_WORD_O[20];
  endproperty
  a_const_one: assert property (p_const_one)
    else $error("const one lost");
  property p_bit1_pin;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[1] == 8'h01 |=> IN_WORD_O[1] == $past(PIN_I[0]);
  endproperty
  a_bit1_pin: assert property (p_bit1_pin)
    else $error("pin route wrong");
  property p_inv_pin;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[0] == 8'h90 |=> IN_WORD_O[0] == !$past(PIN_I[15]);
  endproperty
  a_inv_pin: assert property (p_inv_pin)
    else $error("inverse wrong");
  property p_inv_usb;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[19] == 8'hC7 |=> IN_WORD_O[19] == !$past(USB_PWR_I);
  endproperty
  a_inv_usb: assert property (p_inv_usb)
    else $error("usb inverse wrong");
  property p_dip;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[8] == 8'h50 |=> IN_WORD_O[8] == $past(DIP_I[7]);
  endproperty
  a_dip: assert property (p_dip)
    else $error("dip route wrong");
  property p_bad_code;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[28] == 8'hD0 |=> !IN_WORD_O[28];
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("bad code not 0");
  property p_pin16;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[16] == 8'h10 |=> IN_WORD_O[16] == $past(PIN_I[15]);
  endproperty
  a_pin16: assert property (p_pin16)
    else $error("last pin route wrong");
  property p_enc_a;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[32] == 8'h44 |=> IN_WORD_O[32] == $past(ENC_A_I);
  endproperty
  a_enc_a: assert property (p_enc_a)
    else $error("encoder route wrong");
  property p_zero_code;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && src_sel_ff[7] == 8'h00 |=> !IN_WORD_O[7];
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("const zero lost");
  property p_route_write;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && wr_route && route_idx == 6'h00 |=>
      src_sel_ff[0] == $past(WDATA_I[7:0]);
  endproperty
  a_route_write: assert property (p_route_write)
    else $error("code write lost");
  property p_capture;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && hit && !wr_ctrl |=>
      cap_pos_ff == $past(ACT_POS_I) && cap_raw_ff == $past(RAW_POS_I) &&
      cap_count_ff == $past(cap_count_ff) + 32'h1;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture wrong");
  property p_hold_off;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && cap_mode_ff == IRC_EDGE_OFF && !WR_I |=>
      $stable(cap_pos_ff) && $stable(cap_raw_ff);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("latch while off");
  property p_count_hold;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && !hit && !WR_I |=> cap_count_ff == $past(cap_count_ff);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved");
  property p_rise_only;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && cap_mode_ff == IRC_EDGE_RISE && fall |-> !hit;
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("edge select wrong");
  property p_count_clear;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && wr_ctrl && WDATA_I == 32'h2 |=> cap_count_ff == 32'h0;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("no clear");
  property p_off;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    cap_mode_ff == IRC_EDGE_OFF |-> !hit;
  endproperty
  a_off: assert property (p_off)
    else $error("capture while off");
  c_capture: cover property (@(posedge CLK_SYS_I) CE_I && hit);
  c_irq: cover property (@(posedge CLK_SYS_I) IRQ_O);
  c_both: cover property (@(posedge CLK_SYS_I)
    cap_mode_ff == IRC_EDGE_BOTH && fall);
  c_fall: cover property (@(posedge CLK_SYS_I) CE_I &&
    cap_mode_ff == IRC_EDGE_FALL && fall);
  c_inv: cover property (@(posedge CLK_SYS_I) src_sel_ff[0] == 8'h90);
endmodule : irc_top
`default_nettype wire

// File: tb/irc_far_model.sv
// Far-side model: physical pins, encoder, DIP switches, home switch, position
`timescale 1ns/1ps
`default_nettype none
module irc_far_model (
  input wire logic [27:0] pat_i,
  input wire logic home_i,
  input wire logic [31:0] act_i,
  input wire logic [31:0] raw_i,
  output logic [15:0] pin_o,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_idx_o,
  output logic usb_o,
  output logic [7:0] dip_o,
  output logic home_o,
  output logic [31:0] act_o,
  output logic [31:0] raw_o
);
  // ****************************************
  // Levels
  // ****************************************
  // Bit order of the pattern: pins, enc A, B, index, USB, DIP
  assign {dip_o, usb_o, enc_idx_o, enc_b_o, enc_a_o, pin_o} = pat_i;
  assign home_o = home_i;
  // Position held still around a home edge, so the latch moment is moot
  assign act_o = act_i;
  assign raw_o = raw_i;
endmodule : irc_far_model
`default_nettype wire

// File: tb/tb.sv
// Testbench for input routing and edge capture
`timescale 1ns/1ps
`default_nettype none
`include "irc_consts.svh"
module tb;
  import irc_pkg::*;
  logic clk, rst_n, wr, rd, home, irq, f_a, f_b, f_i, f_u, f_h, e, ce;
  logic [7:0] addr;
  logic [7:0] f_dip;
  logic [15:0] f_pin;
  logic [31:0] wdata, act, raw, rdata, f_act, f_raw, v;
  logic [27:0] pat, p;
  logic [35:0] in_word, w;
  int bad_count, tests_run, n;
  localparam logic [27:0] PAT = 28'hA5C_3961;
  localparam logic [31:0] CNT_EXP [4] = '{32'h0, 32'h1, 32'h1, 32'h2};

  irc_far_model u_far (.pat_i(pat), .home_i(home), .act_i(act),
    .raw_i(raw), .pin_o(f_pin), .enc_a_o(f_a), .enc_b_o(f_b),
    .enc_idx_o(f_i), .usb_o(f_u), .dip_o(f_dip), .home_o(f_h),
    .act_o(f_act), .raw_o(f_raw));

  irc_top u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PIN_I(f_pin), .ENC_A_I(f_a), .ENC_B_I(f_b), .ENC_IDX_I(f_i),
    .USB_PWR_I(f_u), .DIP_I(f_dip), .HOME_I(f_h), .ACT_POS_I(f_act),
    .RAW_POS_I(f_raw), .IN_WORD_O(in_word), .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task summarize;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  task set_home(input logic l);
    @(posedge clk);
    home <= l;
    // Sync chain plus update takes three edges; eight leaves margin
    repeat (8) @(posedge clk);
  endtask : set_home

  function automatic logic exp_bit(input logic [7:0] c,
                                   input logic [27:0] q);
    logic [6:0] l;
    logic s;
    logic ok;
    l = c[6:0];
    s = 1'b0;
    ok = 1'b1;
    if (l >= 7'h01 && l <= 7'h10) s = q[l - 7'h01];
    else if (l >= 7'h44 && l <= 7'h47) s = q[16 + l - 7'h44];
    else if (!c[7] && l >= 7'h49 && l <= 7'h50) s = q[20 + l - 7'h49];
    else ok = 1'b0;
    if (c == 8'h80) return 1'b1;
    if (!ok) return 1'b0;
    return c[7] ? ~s : s;
  endfunction : exp_bit

  initial begin
    #(40 * 20000);
    bad_count++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    home = 1'b0;
    act = 32'h0;
    raw = 32'h0;
    pat = 28'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`IRC_A_ROUTE_CNT, 32'h24);
    for (int i = 1; i <= 36; i++) rd_chk(8'(i), 32'h0);
    rd_chk(`IRC_A_CAP_CNT, 32'h04);
    for (int i = 8'h41; i <= 8'h44; i++) rd_chk(8'(i), 32'h0);
    wr_reg(`IRC_A_ROUTE_CNT, 32'hFF);
    rd_chk(`IRC_A_ROUTE_CNT, 32'h24);
    rd_chk(8'h30, 32'h0);
    // Every code, spread over all entries, with both input polarities
    for (int c = 0; c < 256; c++) begin
      n = c % 36;
      wr_reg(8'(n + 1), 32'(c));
      rd_chk(8'(n + 1), 32'(c));
      for (int k = 0; k < 2; k++) begin
        p = k ? ~PAT : PAT;
        @(posedge clk);
        pat <= p;
        repeat (3) @(posedge clk);
        #1;
        e = exp_bit(8'(c), p);
        chk({31'h0, in_word[n]}, {31'h0, e});
      end
    end
    // No homing run exists here, so arming capture is harmless
    for (int m = 0; m < 4; m++) begin
      wr_reg(`IRC_A_CAP_CTRL, 32'(m));
      @(posedge clk);
      act <= 32'h1234_0000 + 32'(m);
      raw <= 32'hABC0_0000 + 32'(m);
      set_home(1'b1);
      act <= 32'h1234_0010 + 32'(m);
      raw <= 32'hABC0_0010 + 32'(m);
      set_home(1'b0);
      v = (m == 1) ? 32'h1 : 32'h10 + 32'(m);
      rd_chk(`IRC_A_CAP_COUNT, CNT_EXP[m]);
      rd_chk(`IRC_A_CAP_POS, m ? 32'h1234_0000 + v : 32'h0);
      rd_chk(`IRC_A_CAP_RAW, m ? 32'hABC0_0000 + v : 32'h0);
      rd_chk(`IRC_A_CAP_CTRL, 32'(m));
    end
    // A control value above 3 is kept but arms nothing
    wr_reg(`IRC_A_CAP_CTRL, 32'h5);
    set_home(1'b1);
    set_home(1'b0);
    rd_chk(`IRC_A_CAP_COUNT, 32'h2);
    rd_chk(`IRC_A_CAP_CTRL, 32'h5);
    wr_reg(`IRC_A_CAP_CTRL, 32'h3);
    rd_chk(`IRC_A_CAP_COUNT, 32'h0);
    // Interrupt: sticky status, masked, then cleared by writing one
    chk({31'h0, irq}, 32'h0);
    rd_chk(`IRC_A_IRQ_STAT, 32'h1);
    wr_reg(`IRC_A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr_reg(`IRC_A_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd_chk(`IRC_A_IRQ_STAT, 32'h0);
    // Input word readback: each entry keeps the last code of the sweep
    for (int c = 220; c < 256; c++) w[c % 36] = exp_bit(8'(c), ~PAT);
    rd_chk(`IRC_A_IN_WORD_LO, w[31:0]);
    rd_chk(`IRC_A_IN_WORD_HI, {28'h0, w[35:32]});
    // Clock enable low: a write in that window is lost
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`IRC_A_IRQ_MASK, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(`IRC_A_IRQ_MASK, 32'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
